// >>> sbo_alu.sv
`default_nettype none

// ----------------------------------------------------------------
// Combinational shift and bit datapath
// ----------------------------------------------------------------
module sbo_alu (
   // Operation
   input wire sbo_pkg::sbo_op_t op,
   input wire logic [sbo_pkg::SBO_DW-1:0] operand,
   input wire logic [sbo_pkg::SBO_BITW-1:0] bitno,
   input wire logic carry,
   // Result
   output sbo_pkg::sbo_alu_t out
);
   import sbo_pkg::*;

   logic sel;
   logic [SBO_DW-1:0] mask;

   // Selected bit and its one-hot mask
   assign sel = operand[bitno];
   assign mask = SBO_BIT_ONE << bitno;

   // One operation per command; unused fields stay zero, except res, which passes the operand through
   always_comb begin
      out = '0;
      out.res = operand;
      unique case (op)
         op_arith_shift_left, op_logic_shift_left: begin
            out = '{1'b1, {operand[6:0], 1'b0}, 1'b1, operand[7], 1'b0, 1'b0};
         end
         op_arith_shift_right: begin
            out = '{1'b1, {operand[7], operand[7:1]}, 1'b1, operand[0], 1'b0, 1'b0};
         end
         op_logic_shift_right: begin
            out = '{1'b1, {1'b0, operand[7:1]}, 1'b1, operand[0], 1'b0, 1'b0};
         end
         op_rotate_left: begin
            out = '{1'b1, {operand[6:0], operand[7]}, 1'b1, operand[7], 1'b0, 1'b0};
         end
         op_rotate_right: begin
            out = '{1'b1, {operand[0], operand[7:1]}, 1'b1, operand[0], 1'b0, 1'b0};
         end
         op_rotate_carry_left: begin
            out = '{1'b1, {operand[6:0], carry}, 1'b1, operand[7], 1'b0, 1'b0};
         end
         op_rotate_carry_right: begin
            out = '{1'b1, {carry, operand[7:1]}, 1'b1, operand[0], 1'b0, 1'b0};
         end
         op_bit_force_one: begin
            out.res_we = 1'b1;
            out.res = operand | mask;
         end
         op_bit_force_zero: begin
            out.res_we = 1'b1;
            out.res = operand & ~mask;
         end
         op_bit_invert: begin
            out.res_we = 1'b1;
            out.res = operand ^ mask;
         end
         op_bit_test_zero_flag: begin
            out.z_we = 1'b1;
            out.z = ~sel;
         end
         op_carry_and_bit: {out.c_we, out.c} = {1'b1, carry & sel};
         op_carry_and_inv_bit: {out.c_we, out.c} = {1'b1, carry & ~sel};
         op_carry_or_bit: {out.c_we, out.c} = {1'b1, carry | sel};
         op_carry_or_inv_bit: {out.c_we, out.c} = {1'b1, carry | ~sel};
         op_carry_xor_bit: {out.c_we, out.c} = {1'b1, carry ^ sel};
         op_carry_xor_inv_bit: {out.c_we, out.c} = {1'b1, carry ^ ~sel};
         op_bit_to_carry: {out.c_we, out.c} = {1'b1, sel};
         op_inv_bit_to_carry: {out.c_we, out.c} = {1'b1, ~sel};
         op_carry_to_bit: begin
            out.res_we = 1'b1;
            out.res = carry ? (operand | mask) : (operand & ~mask);
         end
         op_inv_carry_to_bit: begin
            out.res_we = 1'b1;
            out.res = carry ? (operand & ~mask) : (operand | mask);
         end
         default: out.res = operand;
      endcase
   end

endmodule

`default_nettype wire

// >>> sbo_far_model.sv
`default_nettype none

// ----------------------------------------------------------------
// Register file and memory on the unit's far side
// ----------------------------------------------------------------
module sbo_far_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Idle cycles before each memory answer
   input wire logic [1:0] wait_n,
   // Register file
   input wire sbo_pkg::sbo_rf_rd_t rf_rd,
   output sbo_pkg::sbo_rf_data_t rf_data,
   // Memory
   input wire sbo_pkg::sbo_mem_req_t mem_req,
   output logic mem_ack,
   output logic [sbo_pkg::SBO_DW-1:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   import sbo_pkg::*;
   logic [SBO_DW-1:0] regs [16];
   logic [SBO_AW-1:0] ptrs [8];
   logic [SBO_DW-1:0] mem [256];
   logic [1:0] cnt_q;
   int wr_count;

   // Register reads answer at once, well inside the fetch cycle
   assign rf_data.byte_data = regs[rf_rd.byte_idx];
   assign rf_data.bitno_data = regs[rf_rd.bitno_idx];
   assign rf_data.ptr_data = ptrs[rf_rd.ptr_idx];

   // One pulse per access after wait_n idle cycles, whole byte each way
   always @(posedge clk) begin
      mem_ack <= 1'b0;
      if (reset) begin
         cnt_q <= 2'h0;
         mem_rdata <= 8'h5a;
         wr_count <= 0;
      end else if (!mem_ack && (mem_req.rd || mem_req.wr) && cnt_q == wait_n) begin
         mem_ack <= 1'b1;
         cnt_q <= 2'h0;
         mem_rdata <= mem[mem_req.addr[7:0]];
         if (mem_req.wr) begin
            mem[mem_req.addr[7:0]] <= mem_req.wdata;
            wr_count <= wr_count + 1;
         end
      end else begin
         cnt_q <= (mem_req.rd || mem_req.wr) && !mem_ack ? cnt_q + 2'h1 : 2'h0;
         mem_rdata <= ~mem_rdata;  // Stale byte and its inverse alternate between answers
      end
   end
endmodule

`default_nettype wire

// >>> sbo_pkg.sv
`default_nettype none

// ----------------------------------------------------------------
// Shared types and constants
// ----------------------------------------------------------------
package sbo_pkg;

   localparam int SBO_DW = 8;
   localparam int SBO_AW = 16;
   localparam int SBO_BITW = 3;
   localparam int SBO_REGW = 4;
   localparam int SBO_PTRW = 3;

   localparam logic [SBO_DW-1:0] SBO_BYTE_ZERO = 8'h00;
   localparam logic [SBO_DW-1:0] SBO_BIT_ONE = 8'h01;
   localparam logic [SBO_AW-1:0] SBO_ADDR_ZERO = 16'h0000;
   localparam logic [7:0] SBO_ABS_PAGE_DEF = 8'hff;

   // Operation codes
   typedef enum logic [4:0] {
      op_arith_shift_left = 5'h00,
      op_arith_shift_right = 5'h01,
      op_logic_shift_left = 5'h02,
      op_logic_shift_right = 5'h03,
      op_rotate_left = 5'h04,
      op_rotate_right = 5'h05,
      op_rotate_carry_left = 5'h06,
      op_rotate_carry_right = 5'h07,
      op_bit_force_one = 5'h08,
      op_bit_force_zero = 5'h09,
      op_bit_invert = 5'h0a,
      op_bit_test_zero_flag = 5'h0b,
      op_carry_and_bit = 5'h0c,
      op_carry_and_inv_bit = 5'h0d,
      op_carry_or_bit = 5'h0e,
      op_carry_or_inv_bit = 5'h0f,
      op_carry_xor_bit = 5'h10,
      op_carry_xor_inv_bit = 5'h11,
      op_bit_to_carry = 5'h12,
      op_inv_bit_to_carry = 5'h13,
      op_carry_to_bit = 5'h14,
      op_inv_carry_to_bit = 5'h15
   } sbo_op_t;

   // Operand addressing
   typedef enum logic [1:0] {
      ea_reg_direct = 2'h0,
      ea_reg_indirect = 2'h1,
      ea_absolute = 2'h2
   } sbo_ea_t;

   // FSM states, Gray along idle-fetch-mem_rd-exec-mem_wr
   typedef enum logic [2:0] {
      st_idle = 3'h0,
      st_fetch = 3'h1,
      st_mem_rd = 3'h3,
      st_exec = 3'h2,
      st_mem_wr = 3'h6
   } sbo_st_t;

   // Decoded instruction
   typedef struct packed {
      sbo_op_t op;
      sbo_ea_t ea;
      logic bit_from_reg;
      logic [SBO_BITW-1:0] imm_bit;
      logic [SBO_REGW-1:0] rn;
      logic [SBO_REGW-1:0] rm;
      logic [7:0] abs_addr;
   } sbo_cmd_t;

   // Register file read addresses
   typedef struct packed {
      logic [SBO_REGW-1:0] byte_idx;
      logic [SBO_REGW-1:0] bitno_idx;
      logic [SBO_PTRW-1:0] ptr_idx;
   } sbo_rf_rd_t;

   // Register file read data
   typedef struct packed {
      logic [SBO_DW-1:0] byte_data;
      logic [SBO_DW-1:0] bitno_data;
      logic [SBO_AW-1:0] ptr_data;
   } sbo_rf_data_t;

   // Memory request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [SBO_AW-1:0] addr;
      logic [SBO_DW-1:0] wdata;
   } sbo_mem_req_t;

   // Write-back to registers and condition flags
   typedef struct packed {
      logic done;
      logic reg_we;
      logic [SBO_REGW-1:0] reg_idx;
      logic [SBO_DW-1:0] reg_data;
      logic c_we;
      logic c;
      logic z_we;
      logic z;
   } sbo_wb_t;

   // Datapath answer
   typedef struct packed {
      logic res_we;
      logic [SBO_DW-1:0] res;
      logic c_we;
      logic c;
      logic z_we;
      logic z;
   } sbo_alu_t;

endpackage

`default_nettype wire

// >>> sbo_unit.sv
`default_nettype none

// What this block does
// - Arithmetic shifts left/right shift a register byte and write it back.
// - Logical shifts left/right shift a register byte and write it back.
// - Plain rotates move the eight register bits among themselves, write back.
// - Rotate-through-carry uses a nine-bit path; register and carry both update.
// - Force-one sets the chosen bit, other seven bits kept.
// - Force-zero clears the chosen bit, other bits kept.
// - Invert complements the chosen bit, other bits kept.
// - Test loads zero flag with the inverse of the chosen bit; operand untouched.
// - Set/clear/invert/test take bit number from immediate or register low bits.
// - Carry becomes carry AND chosen bit.
// - Carry becomes carry AND inverted chosen bit.
// - Carry becomes carry OR chosen bit.
// - Carry becomes carry OR inverted chosen bit.
// - Carry becomes carry XOR chosen bit.
// - Carry becomes carry XOR inverted chosen bit.
// - Load copies chosen bit into carry; operand untouched.
// - Inverted load copies inverse of chosen bit into carry.
// - Store writes carry into chosen bit, other bits kept.
// - Inverted store writes inverse carry into chosen bit.
// - Inverted logic and load forms take bit number only from the immediate.
// - Byte operand is a register, memory via register pointer, or 8-bit absolute.

// ----------------------------------------------------------------
// Shift and bit manipulation execution unit
// ----------------------------------------------------------------
module sbo_unit #(
   parameter logic [7:0] ABS_PAGE = sbo_pkg::SBO_ABS_PAGE_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Command
   input wire logic cmd_valid,
   input wire sbo_pkg::sbo_cmd_t cmd,
   output logic cmd_ready,
   // Condition flags in
   input wire logic carry_in,
   // Register file
   output sbo_pkg::sbo_rf_rd_t rf_rd,
   input wire sbo_pkg::sbo_rf_data_t rf_data,
   // Memory
   output sbo_pkg::sbo_mem_req_t mem_req,
   input wire logic mem_ack,
   input wire logic [sbo_pkg::SBO_DW-1:0] mem_rdata,
   // Write-back
   output sbo_pkg::sbo_wb_t wb
);
   import sbo_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      sbo_st_t st;
      logic ready;
      sbo_cmd_t cmd;
      logic [SBO_DW-1:0] operand;
      logic [SBO_BITW-1:0] bitno;
      sbo_alu_t alu;
      sbo_rf_rd_t rf_rd;
      sbo_mem_req_t mem;
      sbo_wb_t wb;
   } sbo_state_t;

   sbo_state_t s_q;
   sbo_state_t s_d;
   sbo_alu_t alu_out;
   logic is_shift;
   logic inv_form;
   logic to_memory;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------

   // Shifts and rotates only ever act on a register
   assign is_shift = (s_q.cmd.op <= op_rotate_carry_right);

   // Inverted logic and load forms have no register bit number
   assign inv_form = (s_q.cmd.op == op_carry_and_inv_bit) || (s_q.cmd.op == op_carry_or_inv_bit) ||
                     (s_q.cmd.op == op_carry_xor_inv_bit) || (s_q.cmd.op == op_inv_bit_to_carry);

   // Memory operand only for bit ops with a memory mode
   assign to_memory = !is_shift && (s_q.cmd.ea != ea_reg_direct);

   // Datapath works on the latched operand and live carry
   sbo_alu u_alu (
      .op(s_q.cmd.op),
      .operand(s_q.operand),
      .bitno(s_q.bitno),
      .carry(carry_in),
      .out(alu_out)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------

   // Write-back and done are pulses, cleared each cycle by default
   always_comb begin
      s_d = s_q;
      s_d.wb.done = 1'b0;
      s_d.wb.reg_we = 1'b0;
      s_d.wb.c_we = 1'b0;
      s_d.wb.z_we = 1'b0;
      unique case (s_q.st)
         st_idle: begin
            if (cmd_valid) begin
               s_d.cmd = cmd;
               s_d.ready = 1'b0;
               s_d.rf_rd.byte_idx = cmd.rn;
               s_d.rf_rd.bitno_idx = cmd.rm;
               s_d.rf_rd.ptr_idx = cmd.rn[SBO_PTRW-1:0];
               s_d.st = st_fetch;
            end
         end
         st_fetch: begin
            // Register data answers the addresses set last cycle
            s_d.operand = rf_data.byte_data;
            if (s_q.cmd.bit_from_reg && !inv_form && !is_shift) begin
               s_d.bitno = rf_data.bitno_data[SBO_BITW-1:0];
            end else begin
               s_d.bitno = s_q.cmd.imm_bit;
            end
            if (to_memory) begin
               s_d.mem.rd = 1'b1;
               if (s_q.cmd.ea == ea_reg_indirect) begin
                  s_d.mem.addr = rf_data.ptr_data;
               end else begin
                  s_d.mem.addr = {ABS_PAGE, s_q.cmd.abs_addr};
               end
               s_d.st = st_mem_rd;
            end else begin
               s_d.st = st_exec;
            end
         end
         st_mem_rd: begin
            // Hold the read until memory answers
            if (mem_ack) begin
               s_d.mem.rd = 1'b0;
               s_d.operand = mem_rdata;
               s_d.st = st_exec;
            end
         end
         st_exec: begin
            s_d.alu = alu_out;
            if (to_memory && alu_out.res_we) begin
               // Whole byte goes back; flags follow with the ack
               s_d.mem.wr = 1'b1;
               s_d.mem.wdata = alu_out.res;
               s_d.st = st_mem_wr;
            end else begin
               s_d.wb.done = 1'b1;
               s_d.wb.reg_we = alu_out.res_we && !to_memory;
               s_d.wb.reg_idx = s_q.cmd.rn;
               s_d.wb.reg_data = alu_out.res;
               s_d.wb.c_we = alu_out.c_we;
               s_d.wb.c = alu_out.c;
               s_d.wb.z_we = alu_out.z_we;
               s_d.wb.z = alu_out.z;
               s_d.ready = 1'b1;
               s_d.st = st_idle;
            end
         end
         st_mem_wr: begin
            if (mem_ack) begin
               s_d.mem.wr = 1'b0;
               s_d.wb.done = 1'b1;
               s_d.wb.c_we = s_q.alu.c_we;
               s_d.wb.c = s_q.alu.c;
               s_d.wb.z_we = s_q.alu.z_we;
               s_d.wb.z = s_q.alu.z;
               s_d.ready = 1'b1;
               s_d.st = st_idle;
            end
         end
         default: begin
            s_d.st = st_idle;
            s_d.ready = 1'b1;
         end
      endcase
   end

   // Single state register; ready comes up with reset
   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= '0;
         s_q.st <= st_idle;
         s_q.ready <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs are straight state fields
   assign cmd_ready = s_q.ready;
   assign rf_rd = s_q.rf_rd;
   assign mem_req = s_q.mem;
   assign wb = s_q.wb;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   logic exec_reg;
   assign exec_reg = (s_q.st == st_exec) && !to_memory;

   a_shift_left_arith: assert property (
      exec_reg && s_q.cmd.op == op_arith_shift_left |=> wb.reg_we && wb.done &&
      wb.reg_data == {$past(s_q.operand[6:0]), 1'b0} && wb.c == $past(s_q.operand[7]))
      else $error("arithmetic left shift wrong");

   a_shift_right_arith: assert property (
      exec_reg && s_q.cmd.op == op_arith_shift_right |=> wb.reg_we &&
      wb.reg_data[7] == $past(s_q.operand[7]) && wb.c == $past(s_q.operand[0]))
      else $error("arithmetic right shift lost sign");

   a_shift_right_logic: assert property (
      exec_reg && s_q.cmd.op == op_logic_shift_right |=> wb.reg_we &&
      wb.reg_data == {1'b0, $past(s_q.operand[7:1])} && wb.reg_idx == $past(s_q.cmd.rn))
      else $error("logical right shift wrong");

   a_rotate_plain: assert property (
      exec_reg && s_q.cmd.op == op_rotate_left |=> wb.reg_we &&
      wb.reg_data == {$past(s_q.operand[6:0]), $past(s_q.operand[7])})
      else $error("rotate left wrong");

   a_rotate_carry: assert property (
      exec_reg && s_q.cmd.op == op_rotate_carry_right |=> wb.reg_we && wb.c_we &&
      wb.reg_data == {$past(carry_in), $past(s_q.operand[7:1])} && wb.c == $past(s_q.operand[0]))
      else $error("rotate through carry wrong");

   a_bit_modify: assert property (
      exec_reg && s_q.cmd.op == op_bit_force_one |=> wb.reg_we &&
      wb.reg_data == ($past(s_q.operand) | (SBO_BIT_ONE << $past(s_q.bitno))))
      else $error("bit set wrong");

   a_bit_clear: assert property (
      exec_reg && s_q.cmd.op == op_bit_force_zero |=> wb.reg_we &&
      wb.reg_data == ($past(s_q.operand) & ~(SBO_BIT_ONE << $past(s_q.bitno))))
      else $error("bit clear wrong");

   a_bit_flip: assert property (
      exec_reg && s_q.cmd.op == op_bit_invert |=> wb.reg_we &&
      wb.reg_data == ($past(s_q.operand) ^ (SBO_BIT_ONE << $past(s_q.bitno))))
      else $error("bit invert wrong");

   a_test_zero: assert property (
      (s_q.st == st_exec) && s_q.cmd.op == op_bit_test_zero_flag |=> !wb.reg_we && !mem_req.wr &&
      wb.z_we && wb.z == !$past(s_q.operand[s_q.bitno]))
      else $error("bit test wrong");

   a_bitno_source: assert property (
      (s_q.st == st_fetch) && s_q.cmd.bit_from_reg && !inv_form && !is_shift |=>
      s_q.bitno == $past(rf_data.bitno_data[SBO_BITW-1:0]))
      else $error("register bit number not used");

   a_carry_logic: assert property (
      exec_reg && s_q.cmd.op == op_carry_and_inv_bit |=> wb.c_we && !wb.reg_we &&
      wb.c == ($past(carry_in) & !$past(s_q.operand[s_q.bitno])))
      else $error("inverted carry and wrong");

   a_carry_xor: assert property (
      exec_reg && s_q.cmd.op == op_carry_xor_bit |=> wb.c_we &&
      wb.c == ($past(carry_in) ^ $past(s_q.operand[s_q.bitno])))
      else $error("carry xor wrong");

   a_bit_load: assert property (
      exec_reg && s_q.cmd.op == op_bit_to_carry |=> wb.c_we && !wb.reg_we &&
      wb.c == $past(s_q.operand[s_q.bitno]))
      else $error("bit load wrong");

   a_carry_and: assert property (
      exec_reg && s_q.cmd.op == op_carry_and_bit |=>
      wb.c_we && wb.c == ($past(carry_in) & $past(s_q.operand[s_q.bitno])))
      else $error("carry and wrong");

   a_carry_or: assert property (
      exec_reg && s_q.cmd.op == op_carry_or_bit |=>
      wb.c_we && wb.c == ($past(carry_in) | $past(s_q.operand[s_q.bitno])))
      else $error("carry or wrong");

   a_inv_load: assert property (
      exec_reg && s_q.cmd.op == op_inv_bit_to_carry |=>
      wb.c_we && wb.c == !$past(s_q.operand[s_q.bitno]))
      else $error("inverted load wrong");

   a_store_bit: assert property (
      exec_reg && s_q.cmd.op == op_carry_to_bit |=>
      wb.reg_we && wb.reg_data[$past(s_q.bitno)] == $past(carry_in))
      else $error("bit store wrong");

   a_carry_store: assert property (
      exec_reg && s_q.cmd.op == op_inv_carry_to_bit |=> wb.reg_we &&
      wb.reg_data[$past(s_q.bitno)] == !$past(carry_in))
      else $error("inverted store wrong");

   a_inv_immediate: assert property (
      (s_q.st == st_fetch) && inv_form |=> s_q.bitno == $past(s_q.cmd.imm_bit))
      else $error("inverted form took register bit number");

   a_abs_address: assert property (
      (s_q.st == st_fetch) && to_memory && s_q.cmd.ea == ea_absolute |=>
      mem_req.rd && mem_req.addr == {ABS_PAGE, $past(s_q.cmd.abs_addr)})
      else $error("absolute address wrong");

   a_mem_rmw: assert property (
      (s_q.st == st_mem_rd) && mem_ack && s_q.cmd.op == op_bit_force_one |=>
      !mem_req.rd ##1 mem_req.wr && mem_req.addr == $past(mem_req.addr, 2) &&
      mem_req.wdata == ($past(mem_rdata, 2) | (SBO_BIT_ONE << s_q.bitno)))
      else $error("read-modify-write broken");

   a_ready_done: assert property (
      wb.done |-> cmd_ready && $past(!cmd_ready))
      else $error("done without return to ready");

   c_shift_reg: cover property (
      exec_reg && s_q.cmd.op == op_rotate_carry_left ##1 wb.done);

   c_mem_indirect: cover property (
      (s_q.st == st_mem_rd) && s_q.cmd.ea == ea_reg_indirect ##[1:8] (s_q.st == st_mem_wr) ##[1:8] wb.done);

   c_test_memory: cover property (
      (s_q.st == st_exec) && to_memory && s_q.cmd.op == op_bit_test_zero_flag ##1 wb.z_we);

   c_back_to_back: cover property (
      wb.done ##1 (s_q.st == st_fetch));

   c_mem_write: cover property ((s_q.st == st_mem_wr) && mem_ack ##1 wb.done);

endmodule

`default_nettype wire

// >>> shift_and_bit_ops_unit_bench.sv
`default_nettype none

// ----------------------------------------------------------------
// Self-checking bench for the shift and bit unit
// ----------------------------------------------------------------
module shift_and_bit_ops_unit_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import sbo_pkg::*;
   logic clk;
   logic reset;
   logic cmd_valid;
   sbo_cmd_t cmd;
   logic cmd_ready;
   logic carry_in;
   logic [1:0] wait_n;
   sbo_rf_rd_t rf_rd;
   sbo_rf_data_t rf_data;
   sbo_mem_req_t mem_req;
   logic mem_ack;
   logic [SBO_DW-1:0] mem_rdata;
   sbo_wb_t wb;
   sbo_wb_t got;
   int err_total;
   int check_count;
   int cycles;

   sbo_unit dut_u (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
      .carry_in(carry_in), .rf_rd(rf_rd), .rf_data(rf_data), .mem_req(mem_req), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .wb(wb));
   sbo_far_model far_u (.clk(clk), .reset(reset), .wait_n(wait_n), .rf_rd(rf_rd), .rf_data(rf_data),
      .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   // Clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Hang guard; the run needs about 820 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         print_verdict();
      end
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got_v, input logic [15:0] exp_v);
      check_count++;
      if (got_v !== exp_v) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got_v, exp_v);
      end
   endtask

   // Reference result: {byte, carry, zero}
   function automatic logic [9:0] exp_of(sbo_op_t op, logic [7:0] v, logic [2:0] b, logic c);
      logic [7:0] r;
      logic cc;
      logic z;
      r = v;
      cc = c;
      z = 1'b0;
      case (op)
         op_arith_shift_left, op_logic_shift_left: r = {v[6:0], 1'b0};
         op_arith_shift_right: r = {v[7], v[7:1]};
         op_logic_shift_right: r = {1'b0, v[7:1]};
         op_rotate_left: r = {v[6:0], v[7]};
         op_rotate_right: r = {v[0], v[7:1]};
         op_rotate_carry_left: r = {v[6:0], c};
         op_rotate_carry_right: r = {c, v[7:1]};
         op_bit_force_one: r[b] = 1'b1;
         op_bit_force_zero: r[b] = 1'b0;
         op_bit_invert: r[b] = ~v[b];
         op_bit_test_zero_flag: z = ~v[b];
         op_carry_and_bit: cc = c & v[b];
         op_carry_and_inv_bit: cc = c & ~v[b];
         op_carry_or_bit: cc = c | v[b];
         op_carry_or_inv_bit: cc = c | ~v[b];
         op_carry_xor_bit: cc = c ^ v[b];
         op_carry_xor_inv_bit: cc = c ^ ~v[b];
         op_bit_to_carry: cc = v[b];
         op_inv_bit_to_carry: cc = ~v[b];
         op_carry_to_bit: r[b] = c;
         op_inv_carry_to_bit: r[b] = ~c;
         default: r = v;
      endcase
      // Left moves bit 7 out, right moves bit 0 out
      if (op <= op_rotate_carry_right) cc = op[0] ? v[0] : v[7];
      return {r, cc, z};
   endfunction

   // One command, operand rn=3, bit register rm=5, judged at done
   task automatic run(input sbo_op_t op, input sbo_ea_t ea, input logic fr, input logic [2:0] ib,
         input logic ci, input logic [1:0] w);
      logic mem_op;
      logic writes;
      logic [7:0] idx;
      logic [7:0] v;
      logic [2:0] b;
      logic [9:0] e;
      int n0;
      mem_op = op > op_rotate_carry_right && ea != ea_reg_direct;
      idx = ea == ea_absolute ? 8'h40 : far_u.ptrs[3][7:0];
      v = mem_op ? far_u.mem[idx] : far_u.regs[3];
      b = fr && !(op inside {op_carry_and_inv_bit, op_carry_or_inv_bit, op_carry_xor_inv_bit,
         op_inv_bit_to_carry}) ? far_u.regs[5][2:0] : ib;
      e = exp_of(op, v, b, ci);
      writes = !(op == op_bit_test_zero_flag || (op >= op_carry_and_bit && op <= op_inv_bit_to_carry));
      n0 = far_u.wr_count;
      @(posedge clk);
      wait_n <= w;
      carry_in <= ci;
      cmd_valid <= 1'b1;
      cmd <= '{op: op, ea: ea, bit_from_reg: fr, imm_bit: ib, rn: 4'h3, rm: 4'h5, abs_addr: 8'h40};
      @(posedge clk);
      cmd_valid <= 1'b0;
      for (int i = 0; i < 20 && wb.done !== 1'b1; i++) @(negedge clk);
      got = wb;
      chk(got.done, 1'b1);
      chk(cmd_ready, 1'b1);
      if (mem_op) begin
         chk(got.reg_we, 1'b0);
         chk(far_u.mem[idx], writes ? e[9:2] : v);
         chk(16'(far_u.wr_count - n0), writes);
      end else begin
         chk(got.reg_we, writes);
         if (writes) chk({got.reg_idx, got.reg_data}, {4'h3, e[9:2]});
      end
      if (op == op_bit_test_zero_flag) chk({got.z_we, got.z}, {1'b1, e[0]});
      else if (!writes || op <= op_rotate_carry_right) chk({got.c_we, got.c}, {1'b1, e[1]});
   endtask

   // Every shift form, two patterns, both carries; ea must be ignored
   task automatic t_shifts;
      for (int k = 0; k < 32; k++) begin
         far_u.regs[3] = k[4] ? 8'h69 : 8'h96;
         run(sbo_op_t'(k[2:0]), k[3] ? ea_absolute : ea_reg_direct, 1'b0, 3'h0, k[3], 2'h0);
      end
      $display("shift test done");
   endtask

   // Bit writes and test on a register, every bit, immediate and register bit number
   task automatic t_bits_reg;
      sbo_op_t ops [6] = '{op_bit_force_one, op_bit_force_zero, op_bit_invert, op_bit_test_zero_flag,
         op_carry_to_bit, op_inv_carry_to_bit};
      for (int k = 0; k < 96; k++) begin
         far_u.regs[3] = 8'h5a;
         far_u.regs[5] = 8'hf8 | 8'(7 - k % 8);
         run(ops[k / 16], ea_reg_direct, k[3], 3'(k), k[0], 2'h0);
      end
      $display("bit register test done");
   endtask

   // Carry logic and loads; register bit 5 differs from immediate bit 2
   task automatic t_carry_logic;
      far_u.regs[3] = 8'h04;
      far_u.regs[5] = 8'h05;
      for (int k = 0; k < 32; k++) begin
         run(sbo_op_t'(5'h0c + k[4:2]), ea_reg_direct, k[1], k[1] ? 3'h2 : 3'h5, k[0], 2'h0);
      end
      $display("carry logic test done");
   endtask

   // Memory operands through pointer and absolute, with slow answers
   task automatic t_memory;
      sbo_op_t ops [8] = '{op_bit_force_one, op_bit_force_zero, op_bit_invert, op_bit_test_zero_flag,
         op_carry_xor_bit, op_bit_to_carry, op_carry_to_bit, op_inv_carry_to_bit};
      far_u.ptrs[3] = 16'hff20;
      far_u.mem[8'h20] = 8'hc3;
      far_u.mem[8'h40] = 8'h3c;
      far_u.regs[5] = 8'h06;
      for (int k = 0; k < 16; k++) begin
         run(ops[k % 8], k[3] ? ea_absolute : ea_reg_indirect, k[0], 3'(k), k[1], 2'(k));
      end
      $display("memory test done");
   endtask

   // Next command taken in the done cycle
   task automatic t_back_to_back;
      int gap = 0;
      far_u.regs[3] = 8'h81;
      @(posedge clk);
      cmd <= '{op: op_rotate_left, ea: ea_reg_direct, rn: 4'h3, default: '0};
      cmd_valid <= 1'b1;
      repeat (4) @(posedge clk);
      cmd_valid <= 1'b0;
      do begin
         @(negedge clk);
         gap++;
      end while (wb.done !== 1'b1 && gap < 20);
      chk(16'(gap), 16'h0003);
      chk({wb.reg_we, wb.reg_data}, 9'h103);
      $display("back to back test done");
   endtask

   // Main sequence
   initial begin
      err_total = 0;
      check_count = 0;
      cycles = 0;
      reset = 1'b1;
      cmd_valid = 1'b0;
      cmd = '0;
      carry_in = 1'b0;
      wait_n = 2'h0;
      repeat (20) @(posedge clk);
      @(negedge clk);
      chk({cmd_ready, wb.done, mem_req.rd, mem_req.wr}, 4'h8);
      @(posedge clk);
      reset <= 1'b0;
      t_shifts();
      t_bits_reg();
      t_carry_logic();
      t_memory();
      t_back_to_back();
      print_verdict();
   end
endmodule

`default_nettype wire
